// ===== rtl/vdc_device.sv
// decoder control slave: two-wire register port, offset and select
// registers, status byte, no-input substitution, output pin gating
// assumes decoder flags arrive on core_clk; link pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "vdc_map.svh"
module vdc_device (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	vdc_if.dev              link,
	input  wire logic [7:0] y_in,
	input  wire logic [7:0] c_in,
	input  wire logic       c_is_cr,
	input  wire logic [9:0] luma_sum,
	input  wire logic       no_input_detect,
	input  wire logic       vbi_wss_found_flag,
	input  wire logic       extended_data_found_flag,
	input  wire logic       caption_found_flag,
	input  wire logic       gain_loop_mode_flag,
	input  wire logic       burst_pll_unlocked_flag,
	input  wire logic       chroma_kill_active_flag,
	output logic      [7:0] y_pin,
	output logic      [7:0] c_pin,
	output logic            pix_oe,
	output logic            no_input_indicator
);
	vdc_pkg::vdc_dev_s q, next_q;
	logic       scl, sda, rise, fall, start, stop, psave;
	logic [7:0] ya, ca, rd_val;

	// ------------------------------------------------------------
	// alignment line
	// ------------------------------------------------------------
	vdc_ycalign u_align (
		.core_clk (core_clk),
		.resetn   (resetn),
		.code     (q.luma_chroma_offset_code),
		.hold     (psave),
		.y_in     (y_in),
		.c_in     (c_in),
		.y_out    (ya),
		.c_out    (ca)
	);

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	// unmapped sub-addresses read zero, reserved bits read zero
	always_comb begin
		unique case (q.sub)
			`VDC_SUB_OFFSET:  rd_val = {5'h00, q.luma_chroma_offset_code};
			`VDC_SUB_OUTCTL2: rd_val = {6'h00, q.absent_input_output_select};
			`VDC_SUB_STATUS:  rd_val = q.decoder_condition_flags;
			default:          rd_val = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// link conditions from the synchronised pins
	// ------------------------------------------------------------
	assign scl   = q.scl_s[1];
	assign sda   = q.sda_s[1];
	assign rise  = scl & ~q.scl_d;
	assign fall  = ~scl & q.scl_d;
	assign start = scl & q.scl_d & q.sda_d & ~sda;
	assign stop  = scl & q.scl_d & ~q.sda_d & sda;
	assign psave = ~q.pd_s[1];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_q       = q;
		next_q.scl_s = {q.scl_s[0], link.scl};
		next_q.sda_s = {q.sda_s[0], link.sda};
		next_q.oe_s  = {q.oe_s[0], 1'b1};
		next_q.pd_s  = {q.pd_s[0], link.power_save_pin_n};
		next_q.rst_s = {q.rst_s[0], link.device_reset_pin_n};
		next_q.scl_d = scl;
		next_q.sda_d = sda;

		// status byte rebuilt every cycle, msb first
		next_q.decoder_condition_flags = {vbi_wss_found_flag,
			extended_data_found_flag, caption_found_flag,
			gain_loop_mode_flag,
			burst_pll_unlocked_flag,
			luma_sum > `VDC_LUMA_MAX,
			chroma_kill_active_flag,
			no_input_detect};
		next_q.no_input_indicator = no_input_detect;

		// pins off while the reset pin is low; enable is a tie-high input
		next_q.pix_oe = q.oe_s[1] & q.rst_s[1];
		if (psave) begin
			next_q.y_pin = `VDC_PARK_CODE;
			next_q.c_pin = `VDC_PARK_CODE;
		end else if (no_input_detect) begin
			unique case (q.absent_input_output_select)
				2'h1: begin
					next_q.y_pin = `VDC_BLUE_Y;
					next_q.c_pin = c_is_cr ? `VDC_BLUE_CR : `VDC_BLUE_CB;
				end
				2'h2: begin
					next_q.y_pin = ya;
					next_q.c_pin = ca;
				end
				default: begin
					next_q.y_pin = `VDC_BLACK_Y;
					next_q.c_pin = `VDC_BLACK_C;
				end
			endcase
		end else begin
			next_q.y_pin = ya;
			next_q.c_pin = ca;
		end

		// two-wire slave; reset pin returns registers to defaults
		if (!q.rst_s[1]) begin
			next_q.luma_chroma_offset_code    = `VDC_OFFSET_RST;
			next_q.absent_input_output_select = `VDC_SELECT_RST;
			next_q.st     = vdc_pkg::S_IDLE;
			next_q.sda_oe = 1'b0;
		end else if (start) begin
			next_q.st     = vdc_pkg::S_RX;
			next_q.cnt    = 4'h0;
			next_q.kind   = 2'h0;
			next_q.sda_oe = 1'b0;
		end else if (stop) begin
			next_q.st     = vdc_pkg::S_IDLE;
			next_q.sda_oe = 1'b0;
		end else begin
			unique case (q.st)
				vdc_pkg::S_IDLE: begin
				end
				vdc_pkg::S_RX: begin
					if (rise) begin
						next_q.sh  = {q.sh[6:0], sda};
						next_q.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == 4'h8) begin
						next_q.st     = vdc_pkg::S_ACK;
						next_q.sda_oe = 1'b1;
						unique case (q.kind)
							2'h0: begin
								next_q.rw = q.sh[0];
								if (q.sh[7:1] != 7'(`VDC_SLAVE_ADDR >> 1)) begin
									next_q.st     = vdc_pkg::S_IDLE;
									next_q.sda_oe = 1'b0;
								end
							end
							2'h1: next_q.sub = q.sh;
							default: begin
								if (q.sub == `VDC_SUB_OFFSET) begin
									next_q.luma_chroma_offset_code = q.sh[2:0];
								end
								if (q.sub == `VDC_SUB_OUTCTL2) begin
									next_q.absent_input_output_select = q.sh[1:0];
								end
								next_q.sub = q.sub + 8'h01;
							end
						endcase
					end
				end
				vdc_pkg::S_ACK: begin
					if (fall) begin
						next_q.sda_oe = 1'b0;
						next_q.cnt    = 4'h0;
						if (q.kind == 2'h0 && q.rw) begin
							next_q.txb    = rd_val;
							next_q.sh     = rd_val;
							next_q.sda_oe = ~rd_val[7];
							next_q.cnt    = 4'h1;
							next_q.st     = vdc_pkg::S_TX;
						end else begin
							next_q.kind = (q.kind == 2'h0) ? 2'h1 : 2'h2;
							next_q.st   = vdc_pkg::S_RX;
						end
					end
				end
				vdc_pkg::S_TX: begin
					if (fall) begin
						if (q.cnt == 4'h8) begin
							next_q.sda_oe = 1'b0;
							next_q.st     = vdc_pkg::S_RACK;
						end else begin
							next_q.sh     = {q.sh[6:0], 1'b0};
							next_q.sda_oe = ~q.sh[6];
							next_q.cnt    = q.cnt + 4'h1;
						end
					end
				end
				vdc_pkg::S_RACK: begin
					if (rise) begin
						next_q.acked = ~sda;
					end else if (fall) begin
						if (q.acked) begin
							// the latched first byte goes out again
							next_q.sh     = q.txb;
							next_q.sda_oe = ~q.txb[7];
							next_q.cnt    = 4'h1;
							next_q.st     = vdc_pkg::S_TX;
						end else begin
							next_q.st = vdc_pkg::S_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q    <= '0;
			q.st <= vdc_pkg::S_IDLE;
		end else begin
			q <= next_q;
		end
	end

	assign y_pin              = q.y_pin;
	assign c_pin              = q.c_pin;
	assign pix_oe             = q.pix_oe;
	assign no_input_indicator = q.no_input_indicator;
	assign link.dev_sda_o     = 1'b0;
	assign link.dev_sda_oe    = q.sda_oe;
endmodule : vdc_device
`default_nettype wire

// ===== rtl/vdc_host.sv
// controller end: software register port, two-wire master with
// derived clock, power-save pin and reset sequencing
// assumes software on core_clk; data line is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "vdc_map.svh"
module vdc_host (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	vdc_if.host             link,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata
);
	localparam logic [7:0] QUARTER = 8'(`VDC_QUARTER_CYC);
	localparam logic [7:0] HOLD    = 8'(`VDC_RST_HOLD_CYC);
	vdc_pkg::vdc_host_s q, next_q;
	logic sda, tick, rx_byte;

	assign sda     = q.sda_s[1];
	assign tick    = (q.qc == QUARTER - 8'h01);
	assign rx_byte = q.rd_mode && q.step == 2'h3;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_q       = q;
		next_q.sda_s = {q.sda_s[0], link.sda};
		next_q.qc    = tick ? 8'h00 : q.qc + 8'h01;

		// software port, read data one cycle after the strobe
		if (reg_rd) begin
			unique case (reg_addr)
				`VDC_H_SUB:  next_q.rdata = q.sub;
				`VDC_H_DATA: next_q.rdata = q.rdat;
				`VDC_H_STAT: next_q.rdata = {4'h0, q.pd, q.rst_cnt != 8'h00, q.err, q.busy};
				`VDC_H_PWR:  next_q.rdata = {7'h00, q.pd};
				default:     next_q.rdata = 8'h00;
			endcase
		end
		if (reg_wr && reg_addr == `VDC_H_SUB) next_q.sub = reg_wdata;
		if (reg_wr && reg_addr == `VDC_H_DATA) next_q.wdat = reg_wdata;

		// leaving power save starts a fresh reset pulse
		if (q.rst_cnt != 8'h00) next_q.rst_cnt = q.rst_cnt - 8'h01;
		next_q.rst_pin_n = (q.rst_cnt == 8'h00);
		if (reg_wr && reg_addr == `VDC_H_PWR) begin
			next_q.pd       = reg_wdata[0];
			next_q.pd_pin_n = ~reg_wdata[0];
			if (q.pd && !reg_wdata[0]) next_q.rst_cnt = HOLD;
		end

		// transfers refused while busy, powered down or resetting
		if (reg_wr && reg_addr == `VDC_H_CTRL && !q.busy && !q.pd && q.rst_cnt == 8'h00
			&& reg_wdata[1:0] != 2'h0) begin
			next_q.st      = vdc_pkg::H_START;
			next_q.rd_mode = reg_wdata[1];
			next_q.left    = reg_wdata[6:4];
			next_q.step    = 2'h0;
			next_q.ph      = 2'h0;
			next_q.busy    = 1'b1;
			next_q.err     = 1'b0;
		end else if (tick) begin
			next_q.ph = q.ph + 2'h1;
			unique case (q.st)
				vdc_pkg::H_IDLE: begin
					next_q.ph     = 2'h0;
					next_q.scl_oe = 1'b0;
					next_q.sda_oe = 1'b0;
				end
				vdc_pkg::H_START: begin
					// also serves as repeated start from a low clock
					unique case (q.ph)
						2'h0: next_q.sda_oe = 1'b0;
						2'h1: next_q.scl_oe = 1'b0;
						2'h2: next_q.sda_oe = 1'b1;
						default: begin
							next_q.scl_oe = 1'b1;
							next_q.st     = vdc_pkg::H_BYTE;
							next_q.bit_n  = 4'h0;
							next_q.sh     = `VDC_SLAVE_ADDR | {7'h00, q.step == 2'h2};
						end
					endcase
				end
				vdc_pkg::H_BYTE: begin
					unique case (q.ph)
						2'h0: begin
							if (q.bit_n != 4'h8) next_q.sda_oe = rx_byte ? 1'b0 : ~q.sh[7];
							else next_q.sda_oe = rx_byte && q.left != 3'h0;
						end
						2'h1: next_q.scl_oe = 1'b0;
						2'h2: begin
							if (q.bit_n != 4'h8) next_q.sh = {q.sh[6:0], sda};
							else next_q.ack_ok = ~sda;
						end
						default: begin
							next_q.scl_oe = 1'b1;
							next_q.bit_n  = 4'h0;
							if (q.bit_n != 4'h8) begin
								next_q.bit_n = q.bit_n + 4'h1;
							end else if (!rx_byte && !q.ack_ok) begin
								next_q.err = 1'b1;
								next_q.st  = vdc_pkg::H_STOP;
							end else begin
								next_q.step = q.step + 2'h1;
								unique case (q.step)
									2'h0: next_q.sh = q.sub;
									2'h1: begin
										if (q.rd_mode) next_q.st = vdc_pkg::H_START;
										else next_q.sh = q.wdat;
									end
									2'h2: begin
										if (!q.rd_mode) next_q.st = vdc_pkg::H_STOP;
									end
									default: begin
										next_q.rdat = q.sh;
										next_q.step = q.step;
										next_q.left = q.left - 3'h1;
										if (q.left == 3'h0) next_q.st = vdc_pkg::H_STOP;
									end
								endcase
							end
						end
					endcase
				end
				vdc_pkg::H_STOP: begin
					unique case (q.ph)
						2'h0: next_q.sda_oe = 1'b1;
						2'h1: next_q.scl_oe = 1'b0;
						2'h2: next_q.sda_oe = 1'b0;
						default: begin
							next_q.st   = vdc_pkg::H_IDLE;
							next_q.busy = 1'b0;
						end
					endcase
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// power-up itself runs the reset pulse once
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q          <= '0;
			q.st       <= vdc_pkg::H_IDLE;
			q.rst_cnt  <= HOLD;
			q.pd_pin_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata               = q.rdata;
	assign link.host_scl_o         = 1'b0;
	assign link.host_scl_oe        = q.scl_oe;
	assign link.host_sda_o         = 1'b0;
	assign link.host_sda_oe        = q.sda_oe;
	assign link.power_save_pin_n   = q.pd_pin_n;
	assign link.device_reset_pin_n = q.rst_pin_n;
endmodule : vdc_host
`default_nettype wire

// ===== rtl/vdc_if.sv
// two-wire control link plus power-save and reset pins
// open-drain lines resolved here with pull-ups; modules never drive z
`timescale 1ns/1ps
`default_nettype none
interface vdc_if;
	logic scl, sda;
	logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
	logic dev_sda_o, dev_sda_oe;
	logic power_save_pin_n, device_reset_pin_n;

	// wired-and with pull-up
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

	modport dev (input scl, sda, power_save_pin_n, device_reset_pin_n,
		output dev_sda_o, dev_sda_oe);
	modport host (input scl, sda,
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
		output power_save_pin_n, device_reset_pin_n);
endinterface : vdc_if
`default_nettype wire

// ===== rtl/vdc_map.svh
// constants of the video decoder control block: sub-addresses, fields,
// reset values, substitute codes and timing counts
// assumes a 200 MHz core clock on both ends of the control link
`ifndef VDC_MAP_SVH
`define VDC_MAP_SVH

// ------------------------------------------------------------
// device map
// ------------------------------------------------------------
`define VDC_SLAVE_ADDR   8'h88
`define VDC_SUB_OUTCTL2  8'h02
`define VDC_SUB_OFFSET   8'h0b
`define VDC_SUB_STATUS   8'h10
`define VDC_OFFSET_RST   3'h0
`define VDC_SELECT_RST   2'h0
`define VDC_BLACK_Y      8'h10
`define VDC_BLACK_C      8'h80
`define VDC_BLUE_Y       8'h29
`define VDC_BLUE_CB      8'hf0
`define VDC_BLUE_CR      8'h6e
`define VDC_PARK_CODE    8'hff
`define VDC_LUMA_MAX     10'd255

// ------------------------------------------------------------
// controller map and timing
// ------------------------------------------------------------
`define VDC_H_SUB        4'h0
`define VDC_H_DATA       4'h1
`define VDC_H_CTRL       4'h2
`define VDC_H_STAT       4'h3
`define VDC_H_PWR        4'h4
`define VDC_CLK_NS       5
`define VDC_QUARTER_NS   625
`define VDC_QUARTER_CYC  ((`VDC_QUARTER_NS + `VDC_CLK_NS - 1) / `VDC_CLK_NS)
`define VDC_RST_HOLD_NS  1000
`define VDC_RST_HOLD_CYC ((`VDC_RST_HOLD_NS + `VDC_CLK_NS - 1) / `VDC_CLK_NS)

`endif

// ===== rtl/vdc_pkg.sv
// types shared by the decoder control slave and its controller
// assumes vdc_map.svh supplies the numbers
package vdc_pkg;

	// ------------------------------------------------------------
	// slave and controller state machines
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_RX   = 5'h02,
		S_ACK  = 5'h04,
		S_TX   = 5'h08,
		S_RACK = 5'h10
	} vdc_slv_e;

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BYTE  = 4'h4,
		H_STOP  = 4'h8
	} vdc_mst_e;

	// ------------------------------------------------------------
	// state records
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0][7:0] yp;
		logic [2:0][7:0] cp;
		logic [7:0]      y_o;
		logic [7:0]      c_o;
	} vdc_yc_s;

	typedef struct packed {
		logic [1:0] scl_s, sda_s, oe_s, pd_s, rst_s;
		logic       scl_d, sda_d;
		vdc_slv_e   st;
		logic [3:0] cnt;
		logic [7:0] sh, txb, sub;
		logic [1:0] kind;
		logic       rw, acked, sda_oe;
		logic [2:0] luma_chroma_offset_code;
		logic [1:0] absent_input_output_select;
		logic [7:0] decoder_condition_flags;
		logic [7:0] y_pin, c_pin;
		logic       pix_oe, no_input_indicator;
	} vdc_dev_s;

	typedef struct packed {
		vdc_mst_e   st;
		logic [7:0] qc;
		logic [1:0] ph, step;
		logic [3:0] bit_n;
		logic [2:0] left;
		logic [7:0] sh, sub, wdat, rdat, rdata;
		logic       rd_mode, ack_ok, busy, err, pd;
		logic [7:0] rst_cnt;
		logic       rst_pin_n, pd_pin_n, scl_oe, sda_oe;
		logic [1:0] sda_s;
	} vdc_host_s;

endpackage : vdc_pkg

// ===== rtl/vdc_ycalign.sv
// luma/chroma alignment line, up to three stages on either path
// assumes the code is stable and y/c arrive on core_clk
`timescale 1ns/1ps
`default_nettype none
module vdc_ycalign (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] code,
	input  wire logic       hold,
	input  wire logic [7:0] y_in,
	input  wire logic [7:0] c_in,
	output logic      [7:0] y_out,
	output logic      [7:0] c_out
);
	vdc_pkg::vdc_yc_s q, next_q;
	logic [1:0]       ylag, clag;

	// ------------------------------------------------------------
	// tap selection and shift
	// ------------------------------------------------------------
	// negative codes -1 to -3 lag luma (-4 lags neither), positive lag chroma (luma advanced)
	always_comb begin
		next_q = q;
		ylag   = code[2] ? 2'(~code + 3'h1) : 2'h0;
		clag   = code[2] ? 2'h0 : code[1:0];
		// power save freezes the line instead of gating the clock
		if (!hold) begin
			next_q.yp[0] = y_in;
			next_q.cp[0] = c_in;
			for (int i = 1; i < 3; i++) begin
				next_q.yp[i] = q.yp[i-1];
				next_q.cp[i] = q.cp[i-1];
			end
			// one stage per core clock step
			next_q.y_o = (ylag == 2'h0) ? y_in : q.yp[ylag - 2'h1];
			next_q.c_o = (clag == 2'h0) ? c_in : q.cp[clag - 2'h1];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign y_out = q.y_o;
	assign c_out = q.c_o;
endmodule : vdc_ycalign
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: controller and decoder ends joined over the link
// assumes 200 MHz clock; one link transfer costs 15k to 30k cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0] sub, ctl, wd, flg, exp, ey, ec;
	} vdc_row_s;
	logic       core_clk, resetn, reg_wr, reg_rd, c_is_cr, no_input_detect, pix_oe, no_input_indicator;
	logic       vbi_wss_found_flag, extended_data_found_flag, caption_found_flag, gain_loop_mode_flag;
	logic       burst_pll_unlocked_flag, chroma_kill_active_flag;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, y_in, c_in, y_pin, c_pin, d;
	logic [9:0] luma_sum;
	int         err_total, n_checks, cyc;
	vdc_row_s   rows [4];

	vdc_if u_vdc_if ();
	vdc_device u_vdc_device (.core_clk, .resetn, .link(u_vdc_if), .y_in, .c_in, .c_is_cr, .luma_sum,
		.no_input_detect, .vbi_wss_found_flag, .extended_data_found_flag, .caption_found_flag,
		.gain_loop_mode_flag, .burst_pll_unlocked_flag, .chroma_kill_active_flag, .y_pin, .c_pin,
		.pix_oe, .no_input_indicator);
	vdc_host u_vdc_host (.core_clk, .resetn, .link(u_vdc_if), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	vdc_props u_vdc_props (.core_clk, .resetn, .scl(u_vdc_if.scl), .sda(u_vdc_if.sda),
		.host_scl_oe(u_vdc_if.host_scl_oe), .dev_sda_oe(u_vdc_if.dev_sda_oe),
		.power_save_pin_n(u_vdc_if.power_save_pin_n), .device_reset_pin_n(u_vdc_if.device_reset_pin_n));

	// ------------------------------------------------------------
	// clock, video ramp, hang guard
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// equal ramps on both paths make the pin difference the offset
	always @(posedge core_clk) begin
		y_in <= y_in + 8'h01;
		c_in <= c_in + 8'h01;
		cyc++;
		if (cyc == 95000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// poll status until the masked bits drop, bounded
	task automatic wait_clr(input logic [7:0] m);
		int i;
		d = 8'hff;
		for (i = 0; i < 30000 && (d & m) !== 8'h00; i++) rd(4'h3, d);
		if ((d & m) !== 8'h00) begin
			err_total++;
			$display("BAD %0t controller stays busy", $time);
		end
	endtask : wait_clr
	task automatic setf(input logic [7:0] f);
		{vbi_wss_found_flag, extended_data_found_flag, caption_found_flag} <= f[7:5];
		{gain_loop_mode_flag, burst_pll_unlocked_flag} <= f[4:3];
		luma_sum <= f[2] ? 10'h100 : 10'h0ff;
		{chroma_kill_active_flag, no_input_detect} <= f[1:0];
	endtask : setf
	task automatic xfer(input logic [7:0] sub, input logic [7:0] ctl, input logic [7:0] wd);
		wr(4'h0, sub);
		wr(4'h1, wd);
		wr(4'h2, ctl);
		wait_clr(8'h01);
		chk(d & 8'h02, 8'h00);
		rd(4'h1, d);
	endtask : xfer
	task automatic tally_and_finish;
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rows = '{'{8'h0b, 8'h01, 8'hfd, 8'h00, 8'h00, 8'hfd, 8'h00},
			'{8'h0b, 8'h22, 8'h00, 8'h00, 8'h05, 8'hfd, 8'h00},
			'{8'h10, 8'h02, 8'h00, 8'h9f, 8'h9f, 8'h10, 8'h80},
			'{8'h02, 8'h01, 8'h01, 8'h95, 8'h00, 8'h29, 8'h6e}};
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata, y_in, c_in, luma_sum} = '0;
		{vbi_wss_found_flag, extended_data_found_flag, caption_found_flag, gain_loop_mode_flag} = '0;
		{burst_pll_unlocked_flag, chroma_kill_active_flag, no_input_detect} = '0;
		c_is_cr = 1'b1;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk({7'h0, pix_oe}, 8'h00);
		wait_clr(8'h04);
		repeat (8) @(posedge core_clk);
		#1 chk({7'h0, pix_oe}, 8'h01);
		chk(y_pin - c_pin, 8'h00);
		// register traffic with status inputs and video outcome per row
		foreach (rows[i]) begin
			@(posedge core_clk);
			setf(rows[i].flg);
			xfer(rows[i].sub, rows[i].ctl, rows[i].wd);
			if (!rows[i].ctl[0]) chk(d, rows[i].exp);
			chk({7'h0, no_input_indicator}, {7'h0, rows[i].flg[0]});
			if (rows[i].flg[0]) begin
				chk(y_pin, rows[i].ey);
				chk(c_pin, rows[i].ec);
			end else begin
				chk(y_pin - c_pin, rows[i].ey);
			end
		end
		// blue background on a blue-difference chroma sample
		@(posedge core_clk);
		c_is_cr <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1 chk(c_pin, 8'hf0);
		// power save, then release must bring back register defaults
		wr(4'h4, 8'h01);
		repeat (8) @(posedge core_clk);
		#1 chk(y_pin, 8'hff);
		chk(c_pin, 8'hff);
		chk({7'h0, pix_oe}, 8'h01);
		wr(4'h4, 8'h00);
		repeat (4) @(posedge core_clk);
		wait_clr(8'h04);
		repeat (8) @(posedge core_clk);
		#1 chk(c_pin, 8'h80);
		@(posedge core_clk);
		setf(8'h00);
		repeat (8) @(posedge core_clk);
		#1 chk(y_pin - c_pin, 8'h00);
		chk({7'h0, no_input_indicator}, 8'h00);
		// second reset in mid-run
		@(posedge core_clk);
		resetn <= 1'b0;
		@(posedge core_clk);
		#1 chk({7'h0, pix_oe}, 8'h00);
		chk({7'h0, u_vdc_if.device_reset_pin_n}, 8'h00);
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk({7'h0, pix_oe}, 8'h00);
		wait_clr(8'h04);
		repeat (8) @(posedge core_clk);
		#1 chk({7'h0, pix_oe}, 8'h01);
		chk(y_pin - c_pin, 8'h00);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire

// ===== tb/vdc_props.sv
// checker: two-wire link framing, acknowledge slots, reset pin sequencing
// assumes link lines change only on core_clk edges
`timescale 1ns/1ps
`default_nettype none
module vdc_props (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic power_save_pin_n,
	input wire logic device_reset_pin_n
);
	// ------------------------------------------------------------
	// bit and byte tracking
	// ------------------------------------------------------------
	logic [3:0] bitc, nbyte;
	logic [7:0] sh, adr;
	logic       scl_d;
	// a start clears the counts, so a repeated start realigns bytes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{bitc, nbyte, sh, adr, scl_d} <= '0;
		end else begin
			scl_d <= scl;
			if (scl && $fell(sda)) begin
				bitc  <= 4'h0;
				nbyte <= 4'h0;
			end else if (scl && !scl_d) begin
				sh   <= {sh[6:0], sda};
				bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
				if (bitc == 4'h8) begin
					nbyte <= nbyte + 4'h1;
					adr   <= (nbyte == 4'h0) ? sh : adr;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_slot;
		scl && !scl_d && bitc == 4'h8;
	endsequence
	property p_addr_ack; s_slot ##0 (nbyte == 4'h0 && sh[7:1] == 7'h44) |-> !sda; endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
	property p_wr_ack; s_slot ##0 (nbyte != 4'h0 && !adr[0]) |-> !sda; endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
	property p_rd_rel; s_slot ##0 (nbyte != 4'h0 && adr[0]) |-> !dev_sda_oe; endproperty
	a_rd_rel: assert property (p_rd_rel) else $error("slave holds master ack slot");
	property p_oe_low; device_reset_pin_n && $changed(dev_sda_oe) |-> !scl; endproperty
	a_oe_low: assert property (p_oe_low) else $error("slave data moved with clock high");
	property p_scl_hi; $rose(scl) |-> scl [*8]; endproperty
	a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
	property p_start; s_start |-> ##[1:600] !scl; endproperty
	a_start: assert property (p_start) else $error("no clock after start");
	property p_rst_hold; $rose(resetn) |-> !device_reset_pin_n [*8]; endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("device reset too short");
	property p_pd_rst; $rose(power_save_pin_n) |-> ##[0:8] !device_reset_pin_n; endproperty
	a_pd_rst: assert property (p_pd_rst) else $error("no reset after power save");
	property p_quiet; !device_reset_pin_n || !power_save_pin_n |-> !host_scl_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("clocking a held device");
endmodule : vdc_props
`default_nettype wire
